// ---- hdl/card_fmt_cfg.svh ----
/*
  Offsets, field positions, reset values and timing counts of the
  smart card format and transmit-end block.
  Assumes a 32-bit AHB-Lite bus with one word per register.
*/
`ifndef CARD_FMT_CFG_SVH
`define CARD_FMT_CFG_SVH
// ************************************************************
// Register byte offsets
// ************************************************************
`define OFS_CARD_FORMAT 8'h00
`define OFS_SERIAL_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_TX_DATA 8'h0c
`define OFS_RX_DATA 8'h10
`define OFS_HALF_ETU 8'h14
// ************************************************************
// Card format register fields
// ************************************************************
`define FMT_RSVD_ONES 8'hf2
`define FMT_SHIFT_ORDER 3
`define FMT_INVERT 2
`define FMT_CARD_MODE 0
// ************************************************************
// Serial control register fields
// ************************************************************
`define CTL_TX_EN 0
`define CTL_RX_EN 1
`define CTL_GUARD 2
`define CTL_BLOCK 3
`define CTL_SEVEN 4
`define CTL_ODD 5
// ************************************************************
// Status register fields
// ************************************************************
`define ST_TX_BUFFER_EMPTY_FLAG 7
`define ST_ERS 4
`define ST_TX_END_FLAG 2
`define ST_MPB 1
`define ST_TX_MULTIPROC_BIT 0
// ************************************************************
// Transmit-end intervals in half etu (2.5, 1.5 and 1.0 etu)
// ************************************************************
`define TX_END_FLAG_GAP_GT0_BLK0 4'h5
`define TX_END_FLAG_GAP_GT0_BLK1 4'h3
`define TX_END_FLAG_GAP_GT1 4'h2
`define HALF_ETU_RESET 16'h0010
`endif

// ---- hdl/card_fmt_pkg.sv ----
/*
  Types shared by the smart card format block.
  Assumes the constants header is included by the design file.
*/
package card_fmt_pkg;
  // Transmit sequencer, Gray along idle, send, guard
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_GUARD = 2'b11} tx_state_t;
  // Receive sequencer
  typedef enum logic {RX_IDLE = 1'b0, RX_RUN = 1'b1} rx_state_t;
endpackage

// ---- hdl/card_fmt_tx_end.sv ----
/*
  Smart card format control and transmit-end flag logic of one serial
  channel, with a small half-duplex transmitter and receiver and an
  AHB-Lite register slave.
  Assumes a single 50 MHz clock and an open-drain card data line.
*/
`timescale 1ns/1ps
`include "card_fmt_cfg.svh"
// What this block does
// [RULE_01] Transmitter disabled, no error: set transmit-end
// [RULE_02] After byte: set if no error, buffer empty
// [RULE_03] Gap 2.5, 1.5 or 1.0 etu
// [RULE_04] Read one then write zero clears; ones ignored
// [RULE_05] Writing transmit data clears transmit-end
// [RULE_06] Received multiprocessor bit unused in card mode
// [RULE_07] Software keeps multiprocessor transfer bit zero
// [RULE_08] Reserved format bits read as one
// [RULE_09] Shift order bit picks LSB or MSB first
// [RULE_10] Seven-bit characters always LSB first
// [RULE_11] Invert bit inverts sent and stored data
// [RULE_12] Inversion never touches the parity bit
// [RULE_13] Mode bit selects card or normal mode
// [RULE_14] Low error signal sets error status
// [RULE_15] Loading shift register sets buffer-empty flag
// [RULE_16] Intervals counted in bit periods after character
module card_fmt_tx_end
  import card_fmt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe_out,
  output logic tx_end_flag_out,
  output logic tx_buffer_empty_out
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] fmt_q; // Card format, writable bits only
  logic [5:0] ctl_q; // Serial control
  logic [7:0] tdr_q; // Transmit data
  logic [7:0] rdr_q; // Receive data
  logic [15:0] half_q; // Cycles per half etu
  logic tx_buffer_empty_flag_q, ers_q, tx_end_flag_q, mpb_q, tx_multiproc_bit_q; // Status flags
  logic [2:0] arm_q; // Read-as-one seen: tx_buffer_empty_flag, ers, tx_end_flag
  logic [31:0] rdata_q;
  logic wr_q; // Write data phase pending
  logic [7:0] wa_q; // Write address
  // ************************************************************
  // Sequencers and timing
  // ************************************************************
  tx_state_t tx_state_q;
  rx_state_t rx_state_q;
  logic [15:0] div_q;
  logic half_tick;
  logic [4:0] hcnt_q; // Transmit half-etu count
  logic [4:0] rcnt_q; // Receive half-etu count
  logic [9:0] frm_q; // Outgoing frame, bit 0 on the line
  logic [8:0] rsh_q; // Incoming bits
  logic tx_load, guard_done, rx_start, rx_done;
  logic [2:0] sync_q; // Line synchroniser
  logic line_q; // Filtered line level
  logic io_oe_q;
  // Control field views
  logic card_mode, msb_sel, inv_sel, tx_en, rx_en, seven;
  logic [3:0] gap;
  logic [4:0] send_last;
  logic st_wr, txd_wr, st_rd;

  assign card_mode = fmt_q[`FMT_CARD_MODE];
  assign msb_sel = fmt_q[`FMT_SHIFT_ORDER];
  assign inv_sel = fmt_q[`FMT_INVERT];
  assign tx_en = ctl_q[`CTL_TX_EN];
  assign rx_en = ctl_q[`CTL_RX_EN];
  assign seven = ctl_q[`CTL_SEVEN];
  assign st_wr = wr_q && (wa_q == `OFS_STATUS);
  assign txd_wr = wr_q && (wa_q == `OFS_TX_DATA);

  // Order and polarity of data bits; self-inverse, so shared by both paths
  function automatic logic [7:0] fmt_bits(input logic [7:0] d, input logic msb,
                                          input logic inv, input logic sev);
    logic [7:0] r;
    r = d;
    if (msb && !sev) // [RULE_09] [RULE_10]
    begin
      r = {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
    end
    if (inv) // [RULE_11]
    begin
      r = ~r;
    end
    if (sev)
    begin
      r[7] = 1'b0;
    end
    return r;
  endfunction

  // ************************************************************
  // AHB-Lite slave, zero wait states
  // ************************************************************
  logic addr_ok;
  assign addr_ok = hsel_in && hready_in && htrans_in[1];
  assign st_rd = addr_ok && !hwrite_in && (haddr_in == `OFS_STATUS);

  // Address phase capture; read data latched here for the data phase
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else if (hready_in)
    begin
      wr_q <= addr_ok && hwrite_in;
      wa_q <= haddr_in;
      rdata_q <= 32'h0000_0000;
      if (addr_ok && !hwrite_in)
      begin
        case (haddr_in)
          `OFS_CARD_FORMAT: rdata_q[7:0] <= fmt_q | `FMT_RSVD_ONES; // [RULE_08]
          `OFS_SERIAL_CTRL: rdata_q[5:0] <= ctl_q;
          `OFS_STATUS: rdata_q[7:0] <= {tx_buffer_empty_flag_q, 2'b00, ers_q, 1'b0, tx_end_flag_q,
                                        mpb_q, tx_multiproc_bit_q};
          `OFS_TX_DATA: rdata_q[7:0] <= tdr_q;
          `OFS_RX_DATA: rdata_q[7:0] <= rdr_q;
          `OFS_HALF_ETU: rdata_q[15:0] <= half_q;
          default: rdata_q <= 32'h0000_0000; // Unmapped reads zero
        endcase
      end
    end
  end

  // Bus answer: always ready, always OKAY
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
    else
    begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end
  assign hrdata_out = rdata_q;

  // Plain read/write registers
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fmt_q <= 8'h00;
      ctl_q <= 6'h00;
      tdr_q <= 8'h00;
      half_q <= `HALF_ETU_RESET;
      tx_multiproc_bit_q <= 1'b0;
    end
    else if (wr_q)
    begin
      case (wa_q)
        `OFS_CARD_FORMAT: fmt_q <= hwdata_in[7:0] & ~`FMT_RSVD_ONES; // [RULE_13]
        `OFS_SERIAL_CTRL: ctl_q <= hwdata_in[5:0];
        `OFS_TX_DATA: tdr_q <= hwdata_in[7:0];
        `OFS_HALF_ETU: half_q <= hwdata_in[15:0];
        `OFS_STATUS: tx_multiproc_bit_q <= hwdata_in[`ST_TX_MULTIPROC_BIT]; // Kept at zero in card mode
        default: tx_multiproc_bit_q <= tx_multiproc_bit_q; // Unmapped writes dropped
      endcase
    end
  end

  // Read-as-one arming for the clear-by-zero flags
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      arm_q <= 3'b000;
    end
    else if (st_rd)
    begin
      arm_q <= {tx_buffer_empty_flag_q, ers_q, tx_end_flag_q};
    end
  end

  // ************************************************************
  // Status flags; hardware set wins over any clear
  // ************************************************************
  logic ers_set;
  assign ers_set = card_mode && (tx_state_q == TX_GUARD) && half_tick && !line_q;

  // Transmit buffer empty
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_buffer_empty_flag_q <= 1'b1;
    end
    else if (!tx_en || tx_load) // [RULE_15]
    begin
      tx_buffer_empty_flag_q <= 1'b1;
    end
    else if (txd_wr || (st_wr && arm_q[2] && !hwdata_in[`ST_TX_BUFFER_EMPTY_FLAG]))
    begin
      tx_buffer_empty_flag_q <= 1'b0;
    end
  end

  // Error signal status
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ers_q <= 1'b0;
    end
    else if (ers_set) // [RULE_14]
    begin
      ers_q <= 1'b1;
    end
    else if (st_wr && arm_q[1] && !hwdata_in[`ST_ERS])
    begin
      ers_q <= 1'b0;
    end
  end

  // Transmit end
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_end_flag_q <= 1'b1;
    end
    else if (!tx_en && !ers_q) // [RULE_01]
    begin
      tx_end_flag_q <= 1'b1;
    end
    else if (guard_done && !ers_q && !ers_set && tx_buffer_empty_flag_q) // [RULE_02]
    begin
      tx_end_flag_q <= 1'b1;
    end
    else if (txd_wr) // [RULE_05]
    begin
      tx_end_flag_q <= 1'b0;
    end
    else if (st_wr && arm_q[0] && !hwdata_in[`ST_TX_END_FLAG]) // [RULE_04]
    begin
      tx_end_flag_q <= 1'b0;
    end
  end

  // Flag outputs
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_end_flag_out <= 1'b1;
      tx_buffer_empty_out <= 1'b1;
    end
    else
    begin
      tx_end_flag_out <= tx_end_flag_q;
      tx_buffer_empty_out <= tx_buffer_empty_flag_q;
    end
  end

  // ************************************************************
  // Line synchroniser and bit-rate divider
  // ************************************************************
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync_q <= 3'b111;
      line_q <= 1'b1;
    end
    else
    begin
      sync_q <= {sync_q[1:0], card_io_in};
      if (sync_q[1] == sync_q[2]) // Change counts once two stages agree
      begin
        line_q <= sync_q[1];
      end
    end
  end

  // Half-etu ticks; restarted so each character is bit-aligned
  assign half_tick = (div_q == half_q - 16'h0001);
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      div_q <= 16'h0000;
    end
    else if (tx_load || rx_start || half_tick)
    begin
      div_q <= 16'h0000;
    end
    else
    begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  assign tx_load = tx_en && !tx_buffer_empty_flag_q && (tx_state_q == TX_IDLE) && (rx_state_q == RX_IDLE);
  // Start, data and parity bits, two half ticks each
  assign send_last = seven ? 5'd17 : 5'd19;
  // [RULE_03] Gap depends on guard-time and block settings
  assign gap = ctl_q[`CTL_GUARD] ? `TX_END_FLAG_GAP_GT1 :
               (ctl_q[`CTL_BLOCK] ? `TX_END_FLAG_GAP_GT0_BLK1 : `TX_END_FLAG_GAP_GT0_BLK0);
  assign guard_done = (tx_state_q == TX_GUARD) && half_tick && (hcnt_q == {1'b0, gap} - 5'd1)
                      || (tx_state_q == TX_SEND) && half_tick && (hcnt_q == send_last)
                      && !card_mode;

  logic [7:0] tx_ord;
  logic tx_par;
  assign tx_ord = fmt_bits(tdr_q, msb_sel, inv_sel, seven);
  // [RULE_12] Parity from the raw data, not from the inverted bits
  assign tx_par = (seven ? ^tdr_q[6:0] : ^tdr_q) ^ ctl_q[`CTL_ODD];

  // Transmit sequencer
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_state_q <= TX_IDLE;
      hcnt_q <= 5'd0;
      frm_q <= 10'h3ff;
    end
    else
    begin
      case (tx_state_q)
        TX_IDLE:
        begin
          if (tx_load)
          begin
            tx_state_q <= TX_SEND;
            hcnt_q <= 5'd0;
            frm_q <= seven ? {1'b1, tx_par, tx_ord[6:0], 1'b0} : {tx_par, tx_ord, 1'b0};
          end
        end
        TX_SEND:
        begin
          if (half_tick)
          begin
            hcnt_q <= hcnt_q + 5'd1;
            if (hcnt_q[0]) // Next bit every whole etu
            begin
              frm_q <= {1'b1, frm_q[9:1]};
            end
            if (hcnt_q == send_last)
            begin
              hcnt_q <= 5'd0;
              // [RULE_13] Guard wait only in card mode [RULE_16]
              tx_state_q <= card_mode ? TX_GUARD : TX_IDLE;
            end
          end
        end
        TX_GUARD:
        begin
          if (half_tick)
          begin
            hcnt_q <= hcnt_q + 5'd1;
            if (guard_done) // [RULE_03]
            begin
              tx_state_q <= TX_IDLE;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Open-drain drive: enable only while sending a zero
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      io_oe_q <= 1'b0;
    end
    else
    begin
      io_oe_q <= (tx_state_q == TX_SEND) && !frm_q[0];
    end
  end
  assign card_io_oe_out = io_oe_q;
  assign card_io_out = 1'b0;

  // ************************************************************
  // Receiver, only while the transmitter is idle
  // ************************************************************
  assign rx_start = rx_en && (rx_state_q == RX_IDLE) && (tx_state_q == TX_IDLE)
                    && !tx_load && !line_q;
  assign rx_done = (rx_state_q == RX_RUN) && half_tick && (rcnt_q == send_last);

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_state_q <= RX_IDLE;
      rcnt_q <= 5'd0;
      rsh_q <= 9'h000;
    end
    else if (rx_start)
    begin
      rx_state_q <= RX_RUN;
      rcnt_q <= 5'd0;
    end
    else if ((rx_state_q == RX_RUN) && half_tick)
    begin
      rcnt_q <= rcnt_q + 5'd1;
      if (!rcnt_q[0] && (rcnt_q != 5'd0)) // Mid-bit sample
      begin
        rsh_q <= {line_q, rsh_q[8:1]};
      end
      if (rx_done)
      begin
        rx_state_q <= RX_IDLE;
      end
    end
  end

  // Receive data store and multiprocessor bit
  logic [7:0] rx_raw;
  // First mid-bit sample is data bit 0; parity ends up in the top stage
  assign rx_raw = seven ? {1'b0, rsh_q[7:1]} : rsh_q[7:0];
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdr_q <= 8'h00;
      mpb_q <= 1'b0;
    end
    else if (rx_done)
    begin
      rdr_q <= fmt_bits(rx_raw, msb_sel, inv_sel, seven); // [RULE_11]
      mpb_q <= card_mode ? 1'b0 : line_q; // [RULE_06]
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_tx_end_flag_idle;
    @(posedge core_clk_in) disable iff (!rst_n_in) (!tx_en && !ers_q) |=> tx_end_flag_q;
  endproperty
  a_tx_end_flag_idle: assert property (p_tx_end_flag_idle) else $error("tx_end_flag not set when idle"); // [RULE_01]

  property p_tx_end_flag_after;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (guard_done && !ers_q && !ers_set && tx_buffer_empty_flag_q) |=> tx_end_flag_q;
  endproperty
  a_tx_end_flag_after: assert property (p_tx_end_flag_after) else $error("tx_end_flag not set after byte"); // [RULE_02]

  property p_gap_len;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (tx_state_q == TX_GUARD && half_tick && hcnt_q == 5'd1 && ctl_q[`CTL_GUARD])
      |=> tx_state_q == TX_IDLE;
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("guard gap wrong"); // [RULE_03]

  property p_one_ignored;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (tx_end_flag_q && st_wr && hwdata_in[`ST_TX_END_FLAG]) |=> tx_end_flag_q;
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("tx_end_flag cleared by one"); // [RULE_04]

  property p_tdr_clears;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (txd_wr && tx_en && !guard_done) |=> !tx_end_flag_q;
  endproperty
  a_tdr_clears: assert property (p_tdr_clears) else $error("tx_end_flag kept on data write"); // [RULE_05]

  property p_mpb_card;
    @(posedge core_clk_in) disable iff (!rst_n_in) (rx_done && card_mode) |=> !mpb_q;
  endproperty
  a_mpb_card: assert property (p_mpb_card) else $error("mpb set in card mode"); // [RULE_06]

  property p_rsvd;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (addr_ok && !hwrite_in && haddr_in == `OFS_CARD_FORMAT)
      |=> (rdata_q[7:4] == 4'hf) && rdata_q[1];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not one"); // [RULE_08]

  property p_msb_first;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (tx_load && msb_sel && !inv_sel && !seven) |=> frm_q[1] == $past(tdr_q[7]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not first"); // [RULE_09]

  property p_seven_lsb;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (tx_load && seven && !inv_sel) |=> frm_q[1] == $past(tdr_q[0]);
  endproperty
  a_seven_lsb: assert property (p_seven_lsb) else $error("seven bit not lsb first"); // [RULE_10]

  property p_normal_no_guard;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (!card_mode && tx_state_q == TX_SEND) |=> tx_state_q != TX_GUARD;
  endproperty
  a_normal_no_guard: assert property (p_normal_no_guard) else $error("guard in normal"); // [RULE_13]

  property p_ers_set;
    @(posedge core_clk_in) disable iff (!rst_n_in) ers_set |=> ers_q;
  endproperty
  a_ers_set: assert property (p_ers_set) else $error("error status missed"); // [RULE_14]

  property p_load_empty;
    @(posedge core_clk_in) disable iff (!rst_n_in) tx_load |=> tx_buffer_empty_flag_q ##1 tx_state_q == TX_SEND;
  endproperty
  a_load_empty: assert property (p_load_empty) else $error("buffer not empty on load"); // [RULE_15]

  c_byte_sent: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
    guard_done ##1 tx_end_flag_q);
  c_error_seen: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) ers_set);
  c_byte_recv: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) rx_done);
endmodule

// ---- bench/card_model.sv ----
/*
  Behavioural smart card on the open-drain card data line.
  Assumes a pull-up outside: pull_out high drags the line low.
*/
`timescale 1ns/1ps
module card_model #(parameter int HALF = 16)
(
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic err_in,
  input wire logic go_in,
  input wire logic [9:0] bits_in,
  output logic pull_out,
  output logic [9:0] got_out
);
  logic epull = 1'b0; // Error signal drive
  logic spull = 1'b0; // Own frame drive
  logic snd = 1'b0; // Card is sending
  assign pull_out = epull | spull;
  // ************************************************************
  // Receive side
  // ************************************************************
  // Sample ten bits mid-bit; error pulse half an etu into the gap
  initial
  begin
    got_out = '0;
    forever
    begin
      @(negedge line_in);
      if (!snd)
      begin
        repeat (HALF) @(posedge clk_in);
        for (int i = 0; i < 10; i++)
        begin
          got_out[i] = line_in;
          repeat (2 * HALF) @(posedge clk_in);
        end
        // Low level for one etu, only when told to
        if (err_in)
        begin
          epull <= 1'b1;
          repeat (2 * HALF) @(posedge clk_in);
          epull <= 1'b0;
        end
      end
    end
  end
  // ************************************************************
  // Send side
  // ************************************************************
  // Start, data, parity as given; line released after
  initial
  begin
    forever
    begin
      @(posedge go_in);
      snd = 1'b1;
      for (int i = 0; i < 10; i++)
      begin
        spull <= ~bits_in[i];
        repeat (2 * HALF) @(posedge clk_in);
      end
      spull <= 1'b0;
      snd = 1'b0;
    end
  end
endmodule

// ---- bench/testbench.sv ----
/*
  Self-checking bench: AHB-Lite register tasks and a card model.
  Assumes the design answers with zero wait states, half etu 16.
*/
`timescale 1ns/1ps
`include "card_fmt_cfg.svh"
module testbench;
  localparam int H = 16; // Half etu in clocks, reset value
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic io_out;
  logic oe;
  logic tx_end_flag;
  logic tx_buffer_empty_flag;
  logic line;
  logic cpull;
  logic err = 1'b0; // Card answers with an error
  logic go = 1'b0; // Card starts its own frame
  logic [9:0] cbits = '0;
  logic [9:0] got;
  logic [31:0] r;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  // Open drain with pull-up: low while anyone pulls
  assign line = ~(oe | cpull);
  card_fmt_tx_end i_card_fmt_tx_end (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .card_io_in(line), .card_io_out(io_out), .card_io_oe_out(oe),
    .tx_end_flag_out(tx_end_flag), .tx_buffer_empty_out(tx_buffer_empty_flag));
  card_model #(.HALF(H)) i_card_model (
    .clk_in(core_clk_in), .line_in(line), .err_in(err), .go_in(go),
    .bits_in(cbits), .pull_out(cpull), .got_out(got));
  // ************************************************************
  // Clock, timeout, verdict
  // ************************************************************
  initial
  begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  task complete_run;
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the few thousand cycles needed
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      complete_run;
    end
  end
  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One single transfer; entered right after a rising edge
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk_in); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk_in); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  // Gap first: two idle cycles; a read just after a write already sees the new value
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    repeat (2) @(posedge core_clk_in);
    bus(a, 1'b0, 32'h0);
    chk(n, e, r);
    chk("resp", 32'h0, {31'h0, hresp});
  endtask
  // One character out, wire bits and flag timing checked
  task run_tx(input logic [7:0] f, input logic [7:0] c, input logic [7:0] d,
              input logic e, input int gap);
    int t;
    logic [9:0] w;
    logic [7:0] x;
    logic m;
    x = f[2] ? ~d : d;
    m = f[3] & ~c[4];
    w = 10'h000;
    for (int i = 0; i < 8; i++) w[i + 1] = m ? x[7 - i] : x[i];
    // Parity from raw data; idle level after a short character
    if (c[4]) w[9:8] = {1'b1, ^d[6:0] ^ c[5]};
    else w[9] = ^d ^ c[5];
    err <= e;
    bus(`OFS_CARD_FORMAT, 1'b1, {24'h0, f});
    bus(`OFS_SERIAL_CTRL, 1'b1, {24'h0, c});
    bus(`OFS_TX_DATA, 1'b1, {24'h0, d});
    @(posedge oe);
    t = cyc + (c[4] ? 9 : 10) * 2 * H + gap * H;
    @(posedge core_clk_in);
    chk("tx_end_flag_load", 32'h0, {31'h0, tx_end_flag});
    chk("tx_buffer_empty_flag_load", 32'h1, {31'h0, tx_buffer_empty_flag});
    chk("io_out", 32'h0, {31'h0, io_out});
    while (cyc < t - 3) @(posedge core_clk_in);
    chk("tx_end_flag_early", 32'h0, {31'h0, tx_end_flag});
    while (cyc < t + 4) @(posedge core_clk_in);
    chk("tx_end_flag_set", {31'h0, ~e}, {31'h0, tx_end_flag});
    chk("wire", {22'h0, w}, {22'h0, got});
    err <= 1'b0;
    // The card keeps listening one etu past parity; let it rearm
    repeat (2 * H) @(posedge core_clk_in);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    @(posedge core_clk_in);
    rc("fmt", `OFS_CARD_FORMAT, 32'hf2);
    rc("st", `OFS_STATUS, 32'h84);
    rc("half", `OFS_HALF_ETU, 32'h10);
    rc("unmapped", 8'h20, 32'h0);
    bus(`OFS_CARD_FORMAT, 1'b1, 32'hff);
    rc("fmt", `OFS_CARD_FORMAT, 32'hff);
    bus(`OFS_SERIAL_CTRL, 1'b1, 32'h1);
    bus(`OFS_STATUS, 1'b1, 32'hfe);
    rc("st_ones", `OFS_STATUS, 32'h84);
    bus(`OFS_STATUS, 1'b1, 32'h80);
    rc("st_clr", `OFS_STATUS, 32'h80);
    // Guard and block settings, order, invert, length, parity
    run_tx(8'h01, 8'h01, 8'ha5, 1'b0, 5);
    run_tx(8'h09, 8'h09, 8'ha5, 1'b0, 3);
    run_tx(8'h05, 8'h05, 8'h3c, 1'b0, 2);
    run_tx(8'h0d, 8'h1d, 8'h5a, 1'b0, 2);
    run_tx(8'h01, 8'h21, 8'h96, 1'b0, 5);
    run_tx(8'h00, 8'h01, 8'ha5, 1'b0, 0);
    run_tx(8'h01, 8'h01, 8'h69, 1'b1, 5);
    rc("st_err", `OFS_STATUS, 32'h90);
    bus(`OFS_SERIAL_CTRL, 1'b1, 32'h0);
    rc("st_off", `OFS_STATUS, 32'h90);
    bus(`OFS_STATUS, 1'b1, 32'h80);
    rc("st_idle", `OFS_STATUS, 32'h84);
    // Card sends 3d with a set ninth bit; stored inverted
    bus(`OFS_CARD_FORMAT, 1'b1, 32'h05);
    bus(`OFS_SERIAL_CTRL, 1'b1, 32'h02);
    cbits <= {1'b1, 8'h3d, 1'b0};
    go <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
    repeat (24 * H) @(posedge core_clk_in);
    rc("rx", `OFS_RX_DATA, 32'hc2);
    rc("st_mpb", `OFS_STATUS, 32'h84);
    complete_run;
  end
endmodule
